// >>> design/vmc_top.sv
/*
 voltage monitor control: registers over AHB-Lite, two detector channels,
 detector 0 reset start from flash option strap.
 assumes comparator levels and strap synchronous to ref_clk; single-word bus access.
*/
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
// Notes on behaviour
// [RL1] detector 0 result is not readable
// [RL2] detector 1 level valid after enable delay
// [RL3] software configures detector 1 then enables
// [RL4] detector 2 level valid after enable delay
// [RL5] detector 2 input picks supply or pin
// [RL6] detector 0 reset active when option 0
// [RL7] detector 1 stop wakeup needs filter off
// [RL8] detector 2 stop wakeup needs filter off
// [RL9] software sets routing then interrupt type
// [RL10] software picks sample clock, filter mode
// [RL11] edge mode and direction pick timing
// [RL12] software clears change flag before enabling
// [RL13] software starts oscillator for filter use
// [RL14] two sample clocks before enabling filtered interrupt
// [RL15] interrupt enable is the last step
// [RL16] pending flag at enable gives no request
// [RL17] combined writes allowed while interrupt disabled
// [RL18] same silence for detector 2 pending flag
// [RL19] writing 0 clears flag, 1 keeps
// [RL20] sample clock is oscillator divided 1/2/4/8
// [RL21] qualified crossing with enable raises request
`timescale 1ns/100ps
module vmc_top #(
	parameter int EN_ACTIVE_CYC = vmc_pkg::EN_ACTIVE_CYC,
	parameter int OSC_DIV = vmc_pkg::OSC_DIV
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic det0_level,
	input wire logic det1_level,
	input wire logic det2_supply_level,
	input wire logic det2_pin_level,
	input wire logic det0_start_option,
	output logic det0_reset_enable,
	output logic det1_irq,
	output logic det2_irq,
	output logic det1_fast_irq,
	output logic det2_fast_irq
);
	initial begin
		if (OSC_DIV < 2) $error("oscillator divider must be at least 2");
	end
	logic [7:0] detCtl_q;
	logic [7:0] det1Ctl_q;
	logic [7:0] det2Ctl_q;
	logic [7:0] compMode_q;
	logic [7:0] edgeMode_q;
	logic [7:0] clockMode_q;
	logic [7:0] det1Lvl_q;
	logic [7:0] addr_q;
	logic wr_q;
	logic rd_q;
	logic strapTaken_q;
	logic [$clog2(OSC_DIV)-1:0] oscCnt_q;
	logic oscTick_q;
	logic [7:0] wdata;
	logic [7:0] rdNext;
	logic unusedIn;

	vmc_det_if det1 ();
	vmc_det_if det2 ();

	function automatic logic [7:0] ctlRead(input logic [7:0] ctl, input logic flag,
		input logic lvl);
		logic [7:0] v;
		v = ctl;
		v[vmc_pkg::CHG_FLAG_BIT] = flag;
		v[vmc_pkg::LEVEL_BIT] = lvl;
		v[6] = 1'b0;
		return v;
	endfunction

	function automatic logic [7:0] ctlWrite(input logic [7:0] old, input logic [7:0] w);
		logic [7:0] v;
		v = w;
		v[vmc_pkg::LEVEL_BIT] = old[vmc_pkg::LEVEL_BIT];
		v[vmc_pkg::CHG_FLAG_BIT] = 1'b0;
		v[6] = 1'b0;
		return v;
	endfunction

	assign wdata = hwdata[7:0];
	assign unusedIn = ^{haddr[31:8], haddr[1:0], hsize, hwdata[31:8], htrans[0], det0_level};

	// address phase latched; zero-wait slave
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_q <= '0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else if (hready) begin
			addr_q <= haddr[7:0];
			wr_q <= hsel && htrans[1] && hwrite;
			rd_q <= hsel && htrans[1] && !hwrite;
		end
	end

	// full-byte writes take effect at once, so several fields land in one access
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			detCtl_q <= vmc_pkg::DET_CONTROL_RST;
			det1Ctl_q <= vmc_pkg::DET1_CONTROL_RST;
			det2Ctl_q <= vmc_pkg::DET2_CONTROL_RST;
			compMode_q <= vmc_pkg::COMP_MODE_RST;
			edgeMode_q <= vmc_pkg::EDGE_MODE_RST;
			clockMode_q <= vmc_pkg::CLOCK_MODE_RST;
			det1Lvl_q <= vmc_pkg::DET1_LEVEL_RST;
		end else if (wr_q) begin
			case (addr_q) // [RL17]
				vmc_pkg::DET_CONTROL_OFS: begin
					detCtl_q <= wdata;
					detCtl_q[vmc_pkg::D0_EN_BIT] <= detCtl_q[vmc_pkg::D0_EN_BIT];
				end
				vmc_pkg::DET1_CONTROL_OFS: det1Ctl_q <= ctlWrite(det1Ctl_q, wdata);
				vmc_pkg::DET2_CONTROL_OFS: det2Ctl_q <= ctlWrite(det2Ctl_q, wdata);
				vmc_pkg::COMP_MODE_OFS: compMode_q <= wdata;
				vmc_pkg::EDGE_MODE_OFS: edgeMode_q <= wdata;
				vmc_pkg::CLOCK_MODE_OFS: clockMode_q <= wdata;
				vmc_pkg::DET1_LEVEL_OFS: det1Lvl_q <= wdata;
				default: ;
			endcase
		end else if (!strapTaken_q) begin
			// strap caught once after reset release
			detCtl_q[vmc_pkg::D0_EN_BIT] <= !det0_start_option; // [RL6]
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) strapTaken_q <= 1'b0;
		else strapTaken_q <= 1'b1;
	end

	// low-speed oscillator stand-in: a divided enable that stops with its stop bit
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			oscCnt_q <= '0;
			oscTick_q <= 1'b0;
		end else if (clockMode_q[vmc_pkg::OSC_STOP_BIT]) begin
			oscCnt_q <= '0;
			oscTick_q <= 1'b0;
		end else begin
			oscTick_q <= (oscCnt_q == ($bits(oscCnt_q))'(OSC_DIV - 1));
			oscCnt_q <= (oscCnt_q == ($bits(oscCnt_q))'(OSC_DIV - 1)) ? '0 : oscCnt_q + 1'b1;
		end
	end

	assign det1.enable = detCtl_q[vmc_pkg::D1_EN_BIT];
	// only internal reference and supply input are wired for detector 1
	assign det1.levelIn = det1_level;
	assign det1.filterDisable = det1Ctl_q[vmc_pkg::FILT_DIS_BIT];
	assign det1.sampleSel = det1Ctl_q[vmc_pkg::SCLK_LSB +: 2];
	assign det1.edgeBoth = edgeMode_q[vmc_pkg::D1_EDGE_BIT]; // [RL11]
	assign det1.dirBelow = det1Ctl_q[vmc_pkg::DIR_BIT];
	assign det1.irqEnable = det1Ctl_q[vmc_pkg::IRQ_EN_BIT];
	assign det1.oscTick = oscTick_q;
	assign det1.flagClear = wr_q && (addr_q == vmc_pkg::DET1_CONTROL_OFS) &&
		!wdata[vmc_pkg::CHG_FLAG_BIT]; // [RL19]

	assign det2.enable = detCtl_q[vmc_pkg::D2_EN_BIT];
	assign det2.levelIn = detCtl_q[vmc_pkg::D2_IN_BIT] ? det2_pin_level : det2_supply_level; // [RL5]
	assign det2.filterDisable = det2Ctl_q[vmc_pkg::FILT_DIS_BIT];
	assign det2.sampleSel = det2Ctl_q[vmc_pkg::SCLK_LSB +: 2];
	assign det2.edgeBoth = edgeMode_q[vmc_pkg::D2_EDGE_BIT];
	assign det2.dirBelow = det2Ctl_q[vmc_pkg::DIR_BIT];
	assign det2.irqEnable = det2Ctl_q[vmc_pkg::IRQ_EN_BIT];
	assign det2.oscTick = oscTick_q;
	assign det2.flagClear = wr_q && (addr_q == vmc_pkg::DET2_CONTROL_OFS) &&
		!wdata[vmc_pkg::CHG_FLAG_BIT];

	vmc_channel #(.EN_ACTIVE_CYC(EN_ACTIVE_CYC)) u_det1 (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.det(det1)
	);
	vmc_channel #(.EN_ACTIVE_CYC(EN_ACTIVE_CYC)) u_det2 (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.det(det2)
	);

	// detector 0 has no readable level anywhere
	always_comb begin
		case (hready ? haddr[7:0] : addr_q) // [RL1]
			vmc_pkg::DET_CONTROL_OFS: rdNext = detCtl_q;
			vmc_pkg::DET_STATUS_OFS: rdNext = {4'h0, det2.level, 3'h0}; // [RL4]
			vmc_pkg::DET1_CONTROL_OFS: rdNext = ctlRead(det1Ctl_q, det1.flag, det1.level); // [RL2]
			vmc_pkg::DET2_CONTROL_OFS: rdNext = ctlRead(det2Ctl_q, det2.flag, 1'b0);
			vmc_pkg::COMP_MODE_OFS: rdNext = compMode_q;
			vmc_pkg::EDGE_MODE_OFS: rdNext = edgeMode_q;
			vmc_pkg::CLOCK_MODE_OFS: rdNext = clockMode_q;
			vmc_pkg::DET1_LEVEL_OFS: rdNext = det1Lvl_q;
			default: rdNext = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans[1] && !hwrite) hrdata <= {24'h00_0000, rdNext};
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			det0_reset_enable <= 1'b0;
			det1_irq <= 1'b0;
			det2_irq <= 1'b0;
			det1_fast_irq <= 1'b0;
			det2_fast_irq <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= unusedIn & 1'b0;
			det0_reset_enable <= detCtl_q[vmc_pkg::D0_EN_BIT]; // [RL6]
			// routing bit gates requests; type select picks the request line
			det1_irq <= det1.irqPulse && compMode_q[vmc_pkg::ROUTE_BIT] &&
				!compMode_q[vmc_pkg::IRQ1_TYPE_BIT]; // [RL21]
			det1_fast_irq <= det1.irqPulse && compMode_q[vmc_pkg::ROUTE_BIT] &&
				compMode_q[vmc_pkg::IRQ1_TYPE_BIT];
			det2_irq <= det2.irqPulse && compMode_q[vmc_pkg::ROUTE_BIT] &&
				!compMode_q[vmc_pkg::IRQ2_TYPE_BIT];
			det2_fast_irq <= det2.irqPulse && compMode_q[vmc_pkg::ROUTE_BIT] &&
				compMode_q[vmc_pkg::IRQ2_TYPE_BIT];
		end
	end
endmodule

// >>> inc/vmc_pkg.sv
/*
 voltage monitor control: register offsets, field positions, reset values, timing.
 assumes a 125 MHz ref_clk and word-aligned AHB-Lite register access.
*/
package vmc_pkg;
	// byte offsets
	localparam logic [7:0] DET_CONTROL_OFS = 8'h00;
	localparam logic [7:0] DET_STATUS_OFS = 8'h04;
	localparam logic [7:0] DET1_CONTROL_OFS = 8'h08;
	localparam logic [7:0] DET2_CONTROL_OFS = 8'h0C;
	localparam logic [7:0] COMP_MODE_OFS = 8'h10;
	localparam logic [7:0] EDGE_MODE_OFS = 8'h14;
	localparam logic [7:0] CLOCK_MODE_OFS = 8'h18;
	localparam logic [7:0] DET1_LEVEL_OFS = 8'h1C;
	// detector_control_reg bits
	localparam int D1_REF_BIT = 1;
	localparam int D1_IN_BIT = 2;
	localparam int D2_REF_BIT = 3;
	localparam int D2_IN_BIT = 4;
	localparam int D0_EN_BIT = 5;
	localparam int D1_EN_BIT = 6;
	localparam int D2_EN_BIT = 7;
	// detN_control_reg bits
	localparam int IRQ_EN_BIT = 0;
	localparam int FILT_DIS_BIT = 1;
	localparam int CHG_FLAG_BIT = 2;
	localparam int LEVEL_BIT = 3;
	localparam int SCLK_LSB = 4;
	localparam int DIR_BIT = 7;
	// comparator_mode_reg bits
	localparam int IRQ1_TYPE_BIT = 0;
	localparam int IRQ2_TYPE_BIT = 4;
	localparam int ROUTE_BIT = 7;
	// edge_mode_reg bits, clock_mode_reg bit
	localparam int D1_EDGE_BIT = 1;
	localparam int D2_EDGE_BIT = 2;
	localparam int OSC_STOP_BIT = 4;
	// reset values
	localparam logic [7:0] DET_CONTROL_RST = 8'h00;
	localparam logic [7:0] DET1_CONTROL_RST = 8'h8A;
	localparam logic [7:0] DET2_CONTROL_RST = 8'h82;
	localparam logic [7:0] COMP_MODE_RST = 8'h00;
	localparam logic [7:0] EDGE_MODE_RST = 8'h00;
	localparam logic [7:0] CLOCK_MODE_RST = 8'h10;
	localparam logic [7:0] DET1_LEVEL_RST = 8'h00;
	// timing
	localparam int CLK_MHZ = 125;
	localparam int EN_ACTIVE_US = 100;
	localparam int EN_ACTIVE_CYC = EN_ACTIVE_US * CLK_MHZ;
	localparam int OSC_DIV = 1000;
	localparam int FILTER_SAMPLES = 2;
endpackage

// >>> inc/vmc_det_if.sv
/*
 carrier between the control top and one detector channel.
 assumes both ends sit on ref_clk.
*/
`timescale 1ns/100ps
interface vmc_det_if;
	logic enable;
	logic active;
	logic levelIn;
	logic filterDisable;
	logic [1:0] sampleSel;
	logic edgeBoth;
	logic dirBelow;
	logic irqEnable;
	logic oscTick;
	logic flagClear;
	logic flagSet;
	logic flag;
	logic level;
	logic irqPulse;
	modport ctrl(output enable, filterDisable, sampleSel, edgeBoth, dirBelow, irqEnable,
		oscTick, flagClear, levelIn, input active, flagSet, flag, level, irqPulse);
	modport chan(input enable, filterDisable, sampleSel, edgeBoth, dirBelow, irqEnable,
		oscTick, flagClear, levelIn, output active, flagSet, flag, level, irqPulse);
endinterface

// >>> design/vmc_channel.sv
/*
 one detector channel: enable delay, optional digital filter, crossing
 detection, sticky change flag and interrupt request.
 assumes comparator level is synchronous to ref_clk, oscTick one-cycle pulse.
*/
`timescale 1ns/100ps
module vmc_channel #(
	parameter int EN_ACTIVE_CYC = vmc_pkg::EN_ACTIVE_CYC
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	vmc_det_if.chan det
);
	initial begin
		if (EN_ACTIVE_CYC < 1) $error("enable delay must be at least one cycle");
	end
	logic [$clog2(EN_ACTIVE_CYC+1)-1:0] enCnt_q;
	logic active_q;
	logic [2:0] divCnt_q;
	logic sampleTick;
	logic [vmc_pkg::FILTER_SAMPLES-1:0] hist_q;
	logic [vmc_pkg::FILTER_SAMPLES-1:0] histNext;
	logic filt_q;
	logic prev_q;
	logic primed_q;
	logic flag_q;
	logic irqEnPrev_q;
	logic qualified;
	logic crossing;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			enCnt_q <= '0;
			active_q <= 1'b0;
		end else if (!det.enable) begin
			enCnt_q <= '0;
			active_q <= 1'b0;
		end else if (!active_q) begin
			// level only trusted once the comparator has settled
			if (enCnt_q == ($bits(enCnt_q))'(EN_ACTIVE_CYC - 1)) active_q <= 1'b1; // [RL2] [RL4]
			enCnt_q <= enCnt_q + 1'b1;
		end
	end

	// sampling clock is the oscillator tick divided by 1, 2, 4 or 8
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) divCnt_q <= '0;
		else if (det.oscTick) divCnt_q <= divCnt_q + 1'b1;
	end
	always_comb begin
		case (det.sampleSel) // [RL20]
			2'b00: sampleTick = det.oscTick;
			2'b01: sampleTick = det.oscTick && divCnt_q[0];
			2'b10: sampleTick = det.oscTick && (divCnt_q[1:0] == 2'b11);
			default: sampleTick = det.oscTick && (divCnt_q == 3'b111);
		endcase
	end

	// filter passes a level only after it held for all sample slots
	assign histNext = {hist_q[vmc_pkg::FILTER_SAMPLES-2:0], det.levelIn};
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hist_q <= '1;
			filt_q <= 1'b1;
		end else if (sampleTick) begin
			hist_q <= histNext;
			// judged with this sample included, so two sample clocks settle it
			if (&histNext) filt_q <= 1'b1; // [RL14]
			else if (~|histNext) filt_q <= 1'b0;
		end
	end
	assign qualified = det.filterDisable ? det.levelIn : filt_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_q <= 1'b1;
			primed_q <= 1'b0;
		end else begin
			prev_q <= qualified;
			primed_q <= active_q;
		end
	end
	// level 1 means supply at or above threshold; dirBelow picks the falling crossing
	assign crossing = primed_q && active_q && (prev_q != qualified) &&
		(det.edgeBoth || (qualified == !det.dirBelow));

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) flag_q <= 1'b0;
		else if (crossing) flag_q <= 1'b1; // set beats a clear in the same cycle
		else if (det.flagClear) flag_q <= 1'b0; // [RL19]
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irqEnPrev_q <= 1'b0;
			det.irqPulse <= 1'b0;
		end else begin
			irqEnPrev_q <= det.irqEnable;
			// only a fresh crossing requests; a flag pending at enable stays silent
			det.irqPulse <= crossing && det.irqEnable && irqEnPrev_q; // [RL16] [RL18] [RL21]
		end
	end

	assign det.active = active_q;
	assign det.flagSet = crossing;
	assign det.flag = flag_q;
	// disabled detector reads as at-or-above
	assign det.level = active_q ? det.levelIn : 1'b1;
endmodule

// >>> verification/vmc_top_chk.sv
/*
 port-level assertions for the voltage monitor control top.
 assumes binding onto vmc_top, a single ref_clk domain.
*/
`timescale 1ns/100ps
module vmc_top_chk #(
	parameter int EN_ACTIVE_CYC = 4,
	parameter int OSC_DIV = 4
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic det1_level,
	input wire logic det2_supply_level,
	input wire logic det2_pin_level,
	input wire logic det0_start_option,
	input wire logic det0_reset_enable,
	input wire logic det1_irq,
	input wire logic det2_irq,
	input wire logic det1_fast_irq,
	input wire logic det2_fast_irq
);
	// filtered path may need two slow samples plus pipeline
	localparam int AGE_LIM = 24 * OSC_DIV + 16;
	logic lvl1_q;
	logic [1:0] lvl2_q;
	logic [7:0] age1_q;
	logic [7:0] age2_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lvl1_q <= 1'b1;
			age1_q <= 8'hFF;
		end else begin
			lvl1_q <= det1_level;
			if (det1_level != lvl1_q) age1_q <= 8'h00;
			else if (age1_q != 8'hFF) age1_q <= age1_q + 8'h01;
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lvl2_q <= 2'b11;
			age2_q <= 8'hFF;
		end else begin
			lvl2_q <= {det2_supply_level, det2_pin_level};
			if ({det2_supply_level, det2_pin_level} != lvl2_q) age2_q <= 8'h00;
			else if (age2_q != 8'hFF) age2_q <= age2_q + 8'h01;
		end
	end
	a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus answer not zero-wait OKAY");
	a_rdata_quiet: assert property (
		$changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready))
		else $error("read data moved without a read");
	a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	a_det0_arm: assert property (
		$past(arst_n, 2) && $past(arst_n) |-> det0_reset_enable == !det0_start_option)
		else $error("detector 0 reset arm mismatch");
	a_irq1_type: assert property (!(det1_irq && det1_fast_irq))
		else $error("detector 1 both request types");
	a_irq2_type: assert property (!(det2_irq && det2_fast_irq))
		else $error("detector 2 both request types");
	a_irq1_cause: assert property ((det1_irq || det1_fast_irq) |-> age1_q <= AGE_LIM)
		else $error("detector 1 request without crossing");
	a_irq2_cause: assert property ((det2_irq || det2_fast_irq) |-> age2_q <= AGE_LIM)
		else $error("detector 2 request without crossing");
	a_irq1_single: assert property (det1_irq |=> !det1_irq)
		else $error("detector 1 request longer than a cycle");
endmodule
bind vmc_top vmc_top_chk #(.EN_ACTIVE_CYC(EN_ACTIVE_CYC), .OSC_DIV(OSC_DIV)) u_chk (
	.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.det1_level(det1_level), .det2_supply_level(det2_supply_level),
	.det2_pin_level(det2_pin_level), .det0_start_option(det0_start_option),
	.det0_reset_enable(det0_reset_enable), .det1_irq(det1_irq), .det2_irq(det2_irq),
	.det1_fast_irq(det1_fast_irq), .det2_fast_irq(det2_fast_irq));

// >>> verification/tb_voltage_monitor_control.sv
/*
 self-checking bench for vmc_top over AHB-Lite.
 assumes short enable delay and oscillator divider parameters.
*/
`timescale 1ns/100ps
module tb_voltage_monitor_control;
	localparam int EN_CYC = 4;
	localparam int DIV = 4;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic det0_level = 1'b0;
	logic det1_level = 1'b1;
	logic det2_supply_level = 1'b1;
	logic det2_pin_level = 1'b1;
	logic det0_start_option = 1'b0;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic det0_reset_enable;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [3:0] irqV;
	logic [7:0] rstA[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
	logic [7:0] rstV[8] = '{8'h20, 8'h08, 8'h8A, 8'h82, 8'h00, 8'h00, 8'h10, 8'h00};
	logic [7:0] cfgM[4] = '{8'h80, 8'h81, 8'h81, 8'h81};
	logic [7:0] cfgE[4] = '{8'h00, 8'h00, 8'h02, 8'h00};
	logic [7:0] cfgC[4] = '{8'h83, 8'h83, 8'h83, 8'h03};
	int irqCnt[4] = '{0, 0, 0, 0};
	int expCnt[4] = '{0, 0, 0, 0};
	int fail_count = 0;
	int n_tests = 0;
	int seed = 33;
	int lat;
	int per;
	logic [7:0] a;
	// single slave, so its ready is the bus ready
	assign hready = hreadyout;
	vmc_top #(.EN_ACTIVE_CYC(EN_CYC), .OSC_DIV(DIV)) u_dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .det0_level(det0_level),
		.det1_level(det1_level), .det2_supply_level(det2_supply_level),
		.det2_pin_level(det2_pin_level), .det0_start_option(det0_start_option),
		.det0_reset_enable(det0_reset_enable), .det1_irq(irqV[0]), .det1_fast_irq(irqV[1]),
		.det2_irq(irqV[2]), .det2_fast_irq(irqV[3]));
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	// counted on the falling edge, where the request pulses have settled
	always @(negedge ref_clk) begin
		for (int i = 0; i < 4; i++) if (irqV[i] === 1'b1) irqCnt[i]++;
	end
	function automatic int nReq(input logic [7:0] edgeMode);
		// one swing holds one rise and one fall
		return edgeMode[1] ? 2 : 1;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, ad};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge ref_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		xfer(ad, 1'b1, wd);
	endtask
	task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
		xfer(ad, 1'b0, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		idle(20000);
		fail_count++;
		end_of_test();
	end
	initial begin
		idle(2);
		arst_n <= 1'b1;
		idle(3);
		chk({31'h0, det0_reset_enable}, 32'h1);
		for (int k = 0; k < 2; k++) begin
			det0_level <= k[0];
			idle(2);
			for (int i = 0; i < 8; i++) rdchk(rstA[i], {24'h00_0000, rstV[i]});
		end
		for (int i = 0; i < 4; i++) begin
			a = 8'h20 | ($random(seed) & 8'hDC);
			wr(a, $random(seed));
			rdchk(a, 32'h0000_0000);
		end
		done("reset and map");
		wr(8'h00, 32'h0000_0040);
		rdchk(8'h00, 32'h0000_0060);
		idle(EN_CYC + 4);
		rdchk(8'h08, 32'h0000_008A);
		det1_level <= 1'b0;
		idle(4);
		rdchk(8'h08, 32'h0000_0086);
		wr(8'h08, 32'h0000_0082);
		rdchk(8'h08, 32'h0000_0082);
		det1_level <= 1'b1;
		idle(4);
		det1_level <= 1'b0;
		idle(4);
		wr(8'h08, 32'h0000_0086);
		rdchk(8'h08, 32'h0000_0086);
		done("detector 1 level");
		wr(8'h00, 32'h0000_00C0);
		idle(EN_CYC + 4);
		rdchk(8'h04, 32'h0000_0008);
		det2_supply_level <= 1'b0;
		idle(4);
		rdchk(8'h04, 32'h0000_0000);
		wr(8'h00, 32'h0000_00D0);
		idle(4);
		rdchk(8'h04, 32'h0000_0008);
		det2_pin_level <= 1'b0;
		idle(4);
		rdchk(8'h04, 32'h0000_0000);
		det2_pin_level <= 1'b1;
		det2_supply_level <= 1'b1;
		done("detector 2 level");
		wr(8'h10, 32'h0000_0080);
		wr(8'h08, 32'h0000_0087);
		idle(8);
		chk(irqCnt[0], 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(8'h10, {24'h00_0000, cfgM[c]});
			wr(8'h14, {24'h00_0000, cfgE[c]});
			wr(8'h08, {24'h00_0000, cfgC[c]});
			expCnt[cfgM[c][0]] += nReq(cfgE[c]);
			det1_level <= 1'b1;
			idle(4 + ($random(seed) & 3));
			det1_level <= 1'b0;
			idle(6);
			chk(irqCnt[0], expCnt[0]);
			chk(irqCnt[1], expCnt[1]);
		end
		done("detector 1 requests");
		wr(8'h0C, 32'h0000_0087);
		idle(8);
		chk(irqCnt[2], 32'h0);
		wr(8'h18, 32'h0000_0000);
		for (int c = 0; c < 4; c++) begin
			per = DIV << c;
			wr(8'h0C, 32'h0000_0080 | (c << 4));
			idle(2 * per + 4);
			wr(8'h0C, 32'h0000_0081 | (c << 4));
			det2_pin_level <= 1'b0;
			lat = 0;
			while (irqCnt[2] == c && lat < 4 * per + 8) begin
				idle(1);
				lat++;
			end
			chk({31'h0, lat >= per && lat <= 2 * per + 8}, 32'h1);
			det2_pin_level <= 1'b1;
			idle(2 * per + 8);
			chk(irqCnt[2], c + 1);
		end
		chk(irqCnt[3], 32'h0);
		done("detector 2 filter");
		det0_start_option <= 1'b1;
		arst_n <= 1'b0;
		idle(2);
		arst_n <= 1'b1;
		idle(3);
		chk({31'h0, det0_reset_enable}, 32'h0);
		rdchk(8'h00, 32'h0000_0000);
		done("strap off");
		end_of_test();
	end
endmodule
